// ==== ips_core.sv ====
// Interrupt priority service: priority registers, per-cycle polling,
// call generation and in-service tracking.
// Assumes the core gives instruction-end, write and return strobes on mclk,
// and that request flags are already on mclk.
`timescale 1ns/1ns
`default_nettype none
module ips_core
  import ips_pkg::*;
#(
  parameter int NSRC = IPS_NUM_SRC
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // Special-register bus from the core.
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic [7:0]           sfr_wdata,
  input  wire logic                 sfr_page0,
  output logic [7:0]                sfr_rdata,
  output logic                      sfr_hit,
  // Peripheral requests, already gated by their enables.
  input  wire logic [NSRC-1:0]      irq_flag,
  // Instruction sequencer status.
  input  wire logic                 instr_last,
  input  wire logic                 instr_wr_ctrl,
  input  wire logic                 instr_return_from_interrupt,
  // Call sequence towards the core.
  output logic                      call_start,
  output logic                      call_busy,
  output logic                      call_push_pc,
  output logic                      call_load_pc,
  output logic [15:0]               call_vector,
  output logic [IPS_SRC_W-1:0]      call_src,
  output logic [IPS_NUM_LVL-1:0]    in_service
);

  // ---------------------------------------------------------------------------
  // Priority registers
  // ---------------------------------------------------------------------------
  logic [7:0] hi_pri_q, hi_pri_d, lo_pri_q, lo_pri_d;
  logic [7:0] hi_ext_q, hi_ext_d, lo_ext_q, lo_ext_d;
  logic [7:0] hi_ex2_q, hi_ex2_d, lo_ex2_q, lo_ex2_d;

  // Writes mask reserved bits so they always read as zero.
  always_comb begin
    hi_pri_d = hi_pri_q;
    lo_pri_d = lo_pri_q;
    hi_ext_d = hi_ext_q;
    lo_ext_d = lo_ext_q;
    hi_ex2_d = hi_ex2_q;
    lo_ex2_d = lo_ex2_q;
    if (sfr_wr) begin
      unique case (sfr_addr)
        IPS_OFS_HIGH_PRIMARY: hi_pri_d = sfr_wdata & IPS_MASK_PRIMARY;
        IPS_OFS_LOW_PRIMARY:  lo_pri_d = sfr_wdata & IPS_MASK_PRIMARY;
        IPS_OFS_LOW_EXT:      lo_ext_d = sfr_wdata & IPS_MASK_EXT;
        IPS_OFS_HIGH_EXT:     hi_ext_d = sfr_wdata & IPS_MASK_EXT;
        IPS_OFS_LOW_EXT2: begin
          if (sfr_page0) lo_ex2_d = sfr_wdata & IPS_MASK_EXT2;
        end
        IPS_OFS_HIGH_EXT2: begin
          if (sfr_page0) hi_ex2_d = sfr_wdata & IPS_MASK_EXT2;
        end
        default: ;
      endcase
    end
  end

  // Register the priority bits; all clear at reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hi_pri_q <= IPS_RESET_VALUE;
      lo_pri_q <= IPS_RESET_VALUE;
      hi_ext_q <= IPS_RESET_VALUE;
      lo_ext_q <= IPS_RESET_VALUE;
      hi_ex2_q <= IPS_RESET_VALUE;
      lo_ex2_q <= IPS_RESET_VALUE;
    end else begin
      hi_pri_q <= hi_pri_d;
      lo_pri_q <= lo_pri_d;
      hi_ext_q <= hi_ext_d;
      lo_ext_q <= lo_ext_d;
      hi_ex2_q <= hi_ex2_d;
      lo_ex2_q <= lo_ex2_d;
    end
  end

  // Read mux; the core owns the data bus so reads are combinational.
  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = 8'h00;
    unique case (sfr_addr)
      IPS_OFS_HIGH_PRIMARY: sfr_rdata = hi_pri_q;
      IPS_OFS_LOW_PRIMARY:  sfr_rdata = lo_pri_q;
      IPS_OFS_LOW_EXT:      sfr_rdata = lo_ext_q;
      IPS_OFS_HIGH_EXT:     sfr_rdata = hi_ext_q;
      IPS_OFS_LOW_EXT2:     sfr_rdata = sfr_page0 ? lo_ex2_q : 8'h00;
      IPS_OFS_HIGH_EXT2:    sfr_rdata = sfr_page0 ? hi_ex2_q : 8'h00;
      default:              sfr_hit   = 1'b0;
    endcase
    if (!sfr_page0 && (sfr_addr == IPS_OFS_LOW_EXT2 || sfr_addr == IPS_OFS_HIGH_EXT2)) begin
      sfr_hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Level per source
  // ---------------------------------------------------------------------------
  logic [2*NSRC-1:0] src_lvl;

  // High bit is the upper bit of the level, low bit the lower one.
  for (genvar g = 0; g < NSRC; g++) begin : g_lvl
    logic [7:0] hsel, lsel;
    assign hsel = (IPS_GROUP[g] == 2'h0) ? hi_pri_q :
                  (IPS_GROUP[g] == 2'h1) ? hi_ext_q : hi_ex2_q;
    assign lsel = (IPS_GROUP[g] == 2'h0) ? lo_pri_q :
                  (IPS_GROUP[g] == 2'h1) ? lo_ext_q : lo_ex2_q;
    assign src_lvl[2*g +: 2] = {hsel[IPS_BITPOS[g]], lsel[IPS_BITPOS[g]]};
  end

  // ---------------------------------------------------------------------------
  // Polling and call decision
  // ---------------------------------------------------------------------------
  logic                 found;
  logic [IPS_SRC_W-1:0] win;
  logic [1:0]           win_lvl;
  logic                 level_free;
  logic                 take;

  // Fresh resolution every cycle straight from the live flags; nothing is
  // latched, so a request that vanishes while blocked is simply lost.
  ips_resolve #(.NSRC(NSRC)) u_resolve (
    .req     (irq_flag),
    .lvl     (src_lvl),
    .found   (found),
    .win     (win),
    .win_lvl (win_lvl)
  );

  // Any marker at or above the winner's level blocks it.
  assign level_free = ((in_service >> win_lvl) == '0);

  ips_state_e state_q, state_d;
  logic [1:0]           cnt_q, cnt_d;
  logic [IPS_NUM_LVL-1:0] isv_q, isv_d;
  logic [15:0]          vec_q, vec_d;
  logic [IPS_SRC_W-1:0] src_q, src_d;

  assign take = (state_q == IPS_IDLE) && found && level_free && instr_last
                && !instr_wr_ctrl && !instr_return_from_interrupt;

  // Call sequencer and per-level in-service markers.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    isv_d   = isv_q;
    vec_d   = vec_q;
    src_d   = src_q;
    // Return clears only the highest active level; plain return never reaches here.
    if (instr_return_from_interrupt && instr_last) begin
      for (int l = 0; l < IPS_NUM_LVL; l++) begin
        if (isv_q[l] && ((isv_q >> l) == IPS_NUM_LVL'(1))) isv_d[l] = 1'b0;
      end
    end
    unique case (state_q)
      IPS_IDLE: begin
        if (take) begin
          state_d = IPS_CALL;
          cnt_d   = 2'(IPS_CALL_CYC - 1);
          vec_d   = IPS_VECTOR[win];
          src_d   = win;
          isv_d[win_lvl] = 1'b1;
        end
      end
      IPS_CALL: begin
        // Four-cycle call: push cycles first, load vector in the last.
        if (cnt_q == 2'h0) state_d = IPS_IDLE;
        else cnt_d = cnt_q - 2'h1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= IPS_IDLE;
      cnt_q   <= 2'h0;
      isv_q   <= '0;
      vec_q   <= 16'h0000;
      src_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      isv_q   <= isv_d;
      vec_q   <= vec_d;
      src_q   <= src_d;
    end
  end

  // The status word is never saved; the core pushes the PC only.
  assign call_start   = take;
  assign call_busy    = (state_q == IPS_CALL);
  assign call_push_pc = call_busy && (cnt_q != 2'h0);
  assign call_load_pc = call_busy && (cnt_q == 2'h0);
  assign call_vector  = vec_q;
  assign call_src     = src_q;
  assign in_service   = isv_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  call_len_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_start |=> call_busy [*4] ##1 !call_busy)
    else $error("call sequence is not four cycles");

  load_last_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_start |=> !call_load_pc [*3] ##1 call_load_pc)
    else $error("vector not loaded on the last call cycle");

  need_last_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_start |-> instr_last)
    else $error("call outside the last instruction cycle");

  block_ctl_a: assert property (@(posedge mclk) disable iff (!nrst)
    (instr_wr_ctrl || instr_return_from_interrupt) |-> !call_start)
    else $error("call during control write or return");

  no_equal_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_start |-> ((in_service >> win_lvl) == '0))
    else $error("call while equal or higher level in service");

  mark_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_start |=> in_service[$past(win_lvl)])
    else $error("in-service marker not set on call");

  return_from_interrupt_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (instr_return_from_interrupt && instr_last && in_service != '0 && !call_start)
      |=> $countones(in_service) == $countones($past(in_service)) - 1)
    else $error("return did not clear one marker");

  reg_reset_a: assert property (@(posedge mclk)
    !nrst |-> (hi_pri_q == 8'h00 && lo_pri_q == 8'h00 && hi_ext_q == 8'h00
               && lo_ext_q == 8'h00 && hi_ex2_q == 8'h00 && lo_ex2_q == 8'h00))
    else $error("priority register not zero in reset");

  vec_match_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_start |=> call_vector == IPS_VECTOR[call_src])
    else $error("vector does not match source");

  // Independent ranking check: no asking source may outrank the one taken,
  // so a slip in the resolver shows even though the vector table follows it.
  logic [NSRC-1:0] beats_win;

  for (genvar g = 0; g < NSRC; g++) begin : g_beat
    assign beats_win[g] = irq_flag[g] && ((src_lvl[2*g +: 2] > win_lvl) ||
                          ((src_lvl[2*g +: 2] == win_lvl) && (g < int'(win))));
  end

  best_pick_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_start |-> (beats_win == '0) && irq_flag[win] && (src_lvl[2*win +: 2] == win_lvl))
    else $error("call did not go to the best request");

  // Cycles that an eligible request has waited for an instruction end. The
  // bound assumes the core's longest return and longest instruction; a call
  // missed at an instruction end pushes the count past it.
  logic [3:0] wait_q, wait_d;

  always_comb begin
    wait_d = 4'h0;
    if (found && level_free && (state_q == IPS_IDLE) && !take) begin
      wait_d = (wait_q == 4'hF) ? wait_q : wait_q + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_d;
    end
  end

  resp_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
    int'(wait_q) <= IPS_MAX_RESP_CYC - IPS_CALL_CYC - 1)
    else $error("eligible request waited too long for a call");

endmodule // ips_core
`default_nettype wire

// ==== ips_core_bench.sv ====
// Self-checking bench for the interrupt priority service core.
// Assumes the sequencer model drives instruction status; bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module ips_core_bench;
  import ips_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic                 mclk, nrst, sfr_wr, sfr_page0, sfr_hit;
  logic [7:0]           sfr_addr, sfr_wdata, sfr_rdata;
  logic [16:0]          irq_flag;
  logic                 instr_last, instr_wr_ctrl, instr_return_from_interrupt;
  logic                 call_start, call_busy, call_push_pc, call_load_pc;
  logic [15:0]          call_vector;
  logic [IPS_SRC_W-1:0] call_src;
  logic [3:0]           in_service;
  logic [2:0]           ilen;
  logic [1:0]           ikind;
  int                   fails, checks;
  localparam logic [7:0] OFS [6] = '{8'hB7, 8'hB8, 8'hEF, 8'hF7, 8'hFE, 8'hFF};
  localparam logic [7:0] MSK [6] = '{8'h7F, 8'h7F, 8'hBF, 8'hBF, 8'h07, 8'h07};

  ips_core dut (.mclk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_page0, .sfr_rdata,
    .sfr_hit, .irq_flag, .instr_last, .instr_wr_ctrl, .instr_return_from_interrupt, .call_start,
    .call_busy, .call_push_pc, .call_load_pc, .call_vector, .call_src, .in_service);
  ips_core_model seq (.mclk, .nrst, .ilen, .ikind, .call_busy, .instr_last,
    .instr_wr_ctrl, .instr_return_from_interrupt);

  // Free-running 20 MHz clock.
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One write pulse, then one idle cycle, so two calls in a row never set the
  // strobe twice in one time step; the bench always moves 5 ns after the edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #5;
    sfr_wr = 1'b0;
    @(posedge mclk);
    #5;
  endtask

  // Reads are combinational; the data is compared mid-cycle, where it has settled.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    @(negedge mclk);
    `CMP(sfr_rdata, e)
    @(posedge mclk);
    #5;
  endtask

  // No call may start in any of the next n cycles.
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge mclk);
      `CMP(call_start, 1'b0)
    end
    @(posedge mclk);
    #5;
  endtask

  // Waits for a call, then follows the four call cycles to the end.
  task automatic wait_call(input int src, input logic [3:0] isv);
    int n;
    n = 0;
    @(negedge mclk);
    while (call_start !== 1'b1 && n < 30) begin
      n++;
      @(negedge mclk);
    end
    if (n >= 30) begin
      fails++;
      complete_run();
    end
    `CMP(instr_last, 1'b1)
    `CMP(n <= 11, 1'b1)
    @(posedge mclk);
    #5;
    `CMP(call_src, src[4:0])
    `CMP(call_vector, IPS_VECTOR[src])
    `CMP({call_busy, call_push_pc}, 2'h3)
    repeat (3) @(posedge mclk);
    #5;
    `CMP({call_push_pc, call_load_pc}, 2'h1)
    @(posedge mclk);
    #5;
    `CMP({call_busy, in_service}, {1'b0, isv})
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {sfr_wr, sfr_addr, sfr_wdata, irq_flag, ikind} = '0;
    sfr_page0 = 1'b1;
    ilen = 3'h1;
    // A real falling edge on reset, so the registers clear before the first clock.
    nrst = 1'b1;
    #1;
    nrst = 1'b0;
    repeat (6) @(posedge mclk);
    #5;
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) rd(OFS[i], 8'h00);
    for (int i = 0; i < 6; i++) wr(OFS[i], 8'hFF);
    for (int i = 0; i < 6; i++) rd(OFS[i], MSK[i]);
    sfr_page0 = 1'b0;
    wr(8'hFF, 8'h00);
    rd(8'hFF, 8'h00);
    `CMP(sfr_hit, 1'b0)
    sfr_page0 = 1'b1;
    rd(8'hFF, 8'h07);
    `CMP(sfr_hit, 1'b1)
    rd(8'h80, 8'h00);
    `CMP(sfr_hit, 1'b0)
    for (int i = 0; i < 6; i++) wr(OFS[i], 8'h00);
    $display("test registers done");
    // Timer 0 at level 2 and external 0 at level 1 arrive together.
    wr(8'hB7, 8'h02);
    wr(8'hB8, 8'h01);
    irq_flag[3] = 1'b1;
    irq_flag[0] = 1'b1;
    wait_call(3, 4'h4);
    irq_flag[3] = 1'b0;
    quiet(8);
    // External 1 at level 3 pre-empts; timer 1 at level 3 then may not.
    wr(8'hB7, 8'h0E);
    wr(8'hB8, 8'h0D);
    irq_flag[6] = 1'b1;
    wait_call(6, 4'hC);
    irq_flag[6] = 1'b0;
    irq_flag[8] = 1'b1;
    quiet(8);
    // Two one-cycle returns in a row; each clears only the highest marker.
    irq_flag[8] = 1'b0;
    ikind = 2'h2;
    @(posedge mclk);
    #5;
    `CMP(in_service, 4'h4)
    @(posedge mclk);
    #5;
    ikind = 2'h0;
    wait_call(0, 4'h2);
    irq_flag[0] = 1'b0;
    $display("test nesting done");
    // A request seen only during a control write is forgotten.
    ikind = 2'h1;
    irq_flag[3] = 1'b1;
    quiet(3);
    irq_flag[3] = 1'b0;
    ikind = 2'h0;
    quiet(8);
    ilen = 3'h3;
    irq_flag[3] = 1'b1;
    wait_call(3, 4'h6);
    $display("test blocking done");
    complete_run();
  end
endmodule // ips_core_bench
`undef CMP
`default_nettype wire

// ==== ips_core_model.sv ====
// Core sequencer model: instruction ends, control writes and returns.
// Assumes the bench sets instruction length and kind; a call stalls it.
`timescale 1ns/1ns
`default_nettype none
module ips_core_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [2:0] ilen,
  input  wire logic [1:0] ikind,
  input  wire logic       call_busy,
  output logic            instr_last,
  output logic            instr_wr_ctrl,
  output logic            instr_return_from_interrupt
);
  // ---------------------------------------------------------------------------
  // Instruction cycle counter
  // ---------------------------------------------------------------------------
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // Count cycles of the running instruction; a call restarts the count.
  always_comb begin
    cnt_d = cnt_q + 3'h1;
    if (instr_last || call_busy) begin
      cnt_d = 3'h0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // The sequencer is frozen while the call runs, so no end is shown then.
  assign instr_last    = !call_busy && (cnt_q == ilen - 3'h1);
  assign instr_wr_ctrl = (ikind == 2'h1);
  assign instr_return_from_interrupt    = (ikind == 2'h2);
endmodule // ips_core_model
`default_nettype wire

// ==== ips_pkg.sv ====
// Package for the interrupt priority service block: register offsets, reset values,
// source numbering and call timing.
// Assumes a byte-wide special-register bus from the core and one 20 MHz clock.
`default_nettype none
package ips_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IPS_OFS_HIGH_PRIMARY  = 8'hB7;
  localparam logic [7:0] IPS_OFS_LOW_PRIMARY   = 8'hB8;
  localparam logic [7:0] IPS_OFS_LOW_EXT       = 8'hEF;
  localparam logic [7:0] IPS_OFS_HIGH_EXT      = 8'hF7;
  localparam logic [7:0] IPS_OFS_LOW_EXT2      = 8'hFE;
  localparam logic [7:0] IPS_OFS_HIGH_EXT2     = 8'hFF;
  localparam logic [7:0] IPS_RESET_VALUE       = 8'h00;
  localparam logic [7:0] IPS_MASK_PRIMARY      = 8'h7F;
  localparam logic [7:0] IPS_MASK_EXT          = 8'hBF;
  localparam logic [7:0] IPS_MASK_EXT2         = 8'h07;

  // ---------------------------------------------------------------------------
  // Sources, indexed by natural rank (index 0 is the best rank)
  // ---------------------------------------------------------------------------
  localparam int IPS_NUM_SRC = 17;
  localparam int IPS_SRC_W   = 5;
  localparam int IPS_NUM_LVL = 4;

  // Bit position of each source in its register group, in rank order:
  // ext0, brownout, watchdog, timer0, twowire, adc, ext1, pin, timer1,
  // serial0, timer2a, timer2b, timer2c, timer2d, serial1, timer3, wakeup.
  localparam logic [2:0] IPS_BITPOS [IPS_NUM_SRC] = '{
    3'h0, 3'h5, 3'h4, 3'h1, 3'h0, 3'h6, 3'h2, 3'h1, 3'h3,
    3'h4, 3'h2, 3'h3, 3'h5, 3'h7, 3'h0, 3'h1, 3'h2};
  // Register group of each source: 0 primary, 1 extended, 2 second extended.
  localparam logic [1:0] IPS_GROUP [IPS_NUM_SRC] = '{
    2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0,
    2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
  // Vector address of each source.
  localparam logic [15:0] IPS_VECTOR [IPS_NUM_SRC] = '{
    16'h0003, 16'h0043, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
    16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h002B, 16'h0063,
    16'h006B, 16'h0073, 16'h007B, 16'h0083, 16'h008B};

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int IPS_CLK_NS       = 50;
  localparam int IPS_CALL_CYC     = 4;
  localparam int IPS_MIN_RESP_CYC = 5;
  localparam int IPS_MAX_RESP_CYC = 16;

  // One bit for two states, so the sequencer has no illegal code to recover from.
  typedef enum logic {IPS_IDLE, IPS_CALL} ips_state_e;

endpackage : ips_pkg
`default_nettype wire

// ==== ips_resolve.sv ====
// Priority resolver: picks the winning request by level, then natural rank.
// Assumes same-clock inputs; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module ips_resolve
  import ips_pkg::*;
#(
  parameter int NSRC = IPS_NUM_SRC
) (
  input  wire logic [NSRC-1:0]        req,
  input  wire logic [2*NSRC-1:0]      lvl,
  output logic                        found,
  output logic [IPS_SRC_W-1:0]        win,
  output logic [1:0]                  win_lvl
);

  // ---------------------------------------------------------------------------
  // Scan from worst rank to best so the best rank wins ties.
  // ---------------------------------------------------------------------------
  always_comb begin
    found   = 1'b0;
    win     = '0;
    win_lvl = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i] && (!found || lvl[2*i +: 2] >= win_lvl)) begin
        found   = 1'b1;
        win     = IPS_SRC_W'(i);
        win_lvl = lvl[2*i +: 2];
      end
    end
  end

endmodule // ips_resolve
`default_nettype wire
